// *** core/i2c_slave_cfg.svh ***
`ifndef I2C_SLAVE_CFG_SVH
`define I2C_SLAVE_CFG_SVH
// register indices; byte address is four times the index
`define IDX_INT_CTRL  8'h0B
`define IDX_PER_FLAGS 8'h0C
`define IDX_SER_BUF   8'h13
`define IDX_SER_CTRL  8'h14
`define IDX_PORT_DIR  8'h87
`define IDX_PER_EN    8'h8C
`define IDX_SLV_ADDR  8'h93
`define IDX_SER_STAT  8'h94
// reset values
`define RST_PORT_DIR  8'hFF
`define RST_ZERO      8'h00
// field positions
`define BIT_IRQ_FLAG  3
`define BIT_OVF       6
`define BIT_EN        5
`define BIT_CKP       4
`define BIT_DA        5
`define BIT_STOP      4
`define BIT_START     3
`define BIT_RW        2
`define BIT_UA        1
`define BIT_BF        0
`define BIT_SDA_DIR   4
`define BIT_SCL_DIR   3
// port mode codes
`define MODE_SLV7     4'h6
`define MODE_SLV10    4'h7
`define MODE_FW_IDLE  4'hB
`define MODE_SLV7_SS  4'hE
`define MODE_SLV10_SS 4'hF
// bits per byte on the wire
`define BYTE_BITS     4'h8
`endif

// *** core/i2c_slave_pkg.sv ***
package i2c_slave_pkg;
  // slave engine states
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_RX, ST_ACK, ST_TX, ST_TXACK} slv_state_t;
  // apb request from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;
  // one bit per bus line
  typedef struct packed {
    logic scl;
    logic sda;
  } bus_pins_t;
endpackage

// *** core/i2c_slave_port.sv ***
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "i2c_slave_cfg.svh"

module i2c_slave_port
(
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    reset_n,
  // apb slave
  input  wire i2c_slave_pkg::apb_req_t apbReq,
  output logic                         pready,
  output logic [31:0]                  prdata,
  output logic                         pslverr,
  // open-drain bus lines
  input  wire i2c_slave_pkg::bus_pins_t pinIn,
  output i2c_slave_pkg::bus_pins_t     pinOut,
  output i2c_slave_pkg::bus_pins_t     pinOe
);
  import i2c_slave_pkg::*;

  // software registers
  logic [7:0]  intCtrl_q;                  // stored, no logic of its own
  logic [7:0]  perFlags_q;                 // serial irq flag lives here
  logic [7:0]  perEn_q;                    // stored enables
  logic [7:0]  serBuf_q;                   // receive/transmit buffer
  logic [7:0]  serCtrl_q;                  // overflow, enable, release, mode
  logic [7:0]  portDir_q;                  // line direction bits
  logic [7:0]  slvAddr_q;                  // own address in bits 7:1
  logic [7:0]  stat_q;                     // serial status
  // engine
  slv_state_t  state_q;                    // slave state
  slv_state_t  state_d;                    // next state
  logic [7:0]  shift_q;                    // shift register
  logic [7:0]  shift_d;                    // next shift
  logic [3:0]  bitCnt_q;                   // bits in current byte
  logic [3:0]  bitCnt_d;                   // next count
  logic        ackLow_q;                   // slave pulls data for ack
  logic        ackLow_d;                   // next ack drive
  // synchronisers and edge history
  logic        sclS1_q;                    // first stage, clock line
  logic        sclS2_q;                    // second stage, clock line
  logic        sclP_q;                     // previous clock sample
  logic        sdaS1_q;                    // first stage, data line
  logic        sdaS2_q;                    // second stage, data line
  logic        sdaP_q;                     // previous data sample
  // pin and bus outputs
  bus_pins_t   pinOe_q;                    // drive enables
  bus_pins_t   pinOut_q;                   // driven level, always low
  logic        pready_q;                   // apb ready
  logic [31:0] prdata_q;                   // apb read data
  logic        pslverr_q;                  // apb error
  // next values of the register file
  logic [7:0]  stat_d;                     // next status
  logic [7:0]  ctrl_d;                     // next control
  logic [7:0]  flags_d;                    // next flags
  logic [7:0]  buf_d;                      // next buffer
  // one-cycle engine events and next status bits
  logic        byteFlag;                   // byte finished
  logic        loadBuf;                    // copy shifter into buffer
  logic        setOvf;                     // overflow seen
  logic        clrCkp;                     // start clock stretch
  logic        dropStat;                   // slave status reset
  logic        newRw;                      // next direction bit
  logic        newDa;                      // next data/address bit

  // register index decode
  function automatic logic isMapped(input logic [7:0] i);
    isMapped = (i == `IDX_INT_CTRL) || (i == `IDX_PER_FLAGS) ||
               (i == `IDX_SER_BUF)  || (i == `IDX_SER_CTRL)  ||
               (i == `IDX_PORT_DIR) || (i == `IDX_PER_EN)    ||
               (i == `IDX_SLV_ADDR) || (i == `IDX_SER_STAT);
  endfunction

  // apb phase and address decode
  wire       setupPh = apbReq.psel & ~apbReq.penable;
  wire       accessPh = apbReq.psel & apbReq.penable & pready_q;
  wire [7:0] idx = apbReq.paddr[9:2];
  wire       addrOk = (apbReq.paddr[1:0] == 2'h0) && (apbReq.paddr[11:10] == 2'h0)
                      && isMapped(idx);
  wire       wrEn = accessPh & apbReq.pwrite & addrOk;
  wire       rdEn = accessPh & ~apbReq.pwrite & addrOk;
  wire [7:0] wData = apbReq.pwdata[7:0];
  wire       wrIntCtrl = wrEn && (idx == `IDX_INT_CTRL);
  wire       wrFlags = wrEn && (idx == `IDX_PER_FLAGS);
  wire       wrBuf = wrEn && (idx == `IDX_SER_BUF);
  wire       wrCtrl = wrEn && (idx == `IDX_SER_CTRL);
  wire       wrDir = wrEn && (idx == `IDX_PORT_DIR);
  wire       wrPerEn = wrEn && (idx == `IDX_PER_EN);
  wire       wrAddr = wrEn && (idx == `IDX_SLV_ADDR);
  wire       wrStat = wrEn && (idx == `IDX_SER_STAT);
  wire       rdBuf = rdEn && (idx == `IDX_SER_BUF);

  // read selection
  wire [7:0] rdSel = (idx == `IDX_INT_CTRL)  ? intCtrl_q  :
                     (idx == `IDX_PER_FLAGS) ? perFlags_q :
                     (idx == `IDX_SER_BUF)   ? serBuf_q   :
                     (idx == `IDX_SER_CTRL)  ? serCtrl_q  :
                     (idx == `IDX_PORT_DIR)  ? portDir_q  :
                     (idx == `IDX_PER_EN)    ? perEn_q    :
                     (idx == `IDX_SLV_ADDR)  ? slvAddr_q  :
                     (idx == `IDX_SER_STAT)  ? stat_q     : `RST_ZERO;

  // mode decode
  wire [3:0] mode = serCtrl_q[3:0];
  wire       portOn = serCtrl_q[`BIT_EN];
  wire       slvOn = portOn && ((mode == `MODE_SLV7) || (mode == `MODE_SLV10) ||
                     (mode == `MODE_SLV7_SS) || (mode == `MODE_SLV10_SS));
  wire       ssOn = portOn && ((mode == `MODE_FW_IDLE) || (mode == `MODE_SLV7_SS) ||
                    (mode == `MODE_SLV10_SS));

  // bus edges and conditions
  wire       sclRise = sclS2_q & ~sclP_q;
  wire       sclFall = ~sclS2_q & sclP_q;
  wire       startEv = portOn & sclS2_q & sclP_q & ~sdaS2_q & sdaP_q;
  wire       stopEv = portOn & sclS2_q & sclP_q & sdaS2_q & ~sdaP_q;
  wire       ovfCond = stat_q[`BIT_BF] | serCtrl_q[`BIT_OVF];
  wire       addrHit = shift_q[7:1] == slvAddr_q[7:1];
  wire       lastFall = sclFall && (bitCnt_q == `BYTE_BITS);
  wire       txBitLow = slvOn && (state_q == ST_TX) && !shift_q[7];

  // two-stage synchronisers, then edge history
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      {sclS1_q, sclS2_q, sclP_q} <= 3'h7;
      {sdaS1_q, sdaS2_q, sdaP_q} <= 3'h7;
    end
    else
    begin
      {sclS1_q, sclS2_q, sclP_q} <= {pinIn.scl, sclS1_q, sclS2_q};
      {sdaS1_q, sdaS2_q, sdaP_q} <= {pinIn.sda, sdaS1_q, sdaS2_q};
    end
  end

  // slave engine and register side effects
  always_comb
  begin
    state_d = state_q;
    shift_d = shift_q;
    bitCnt_d = bitCnt_q;
    ackLow_d = ackLow_q;
    byteFlag = 1'b0;
    loadBuf = 1'b0;
    setOvf = 1'b0;
    clrCkp = 1'b0;
    dropStat = 1'b0;
    newRw = stat_q[`BIT_RW];
    newDa = stat_q[`BIT_DA];
    // slave runs whatever the direction bits say
    if (!slvOn)
    begin
      state_d = ST_IDLE;
      ackLow_d = 1'b0;
    end
    else if (startEv)
    begin
      state_d = ST_ADDR;
      bitCnt_d = 4'h0;
      ackLow_d = 1'b0;
    end
    else if (stopEv)
    begin
      state_d = ST_IDLE;
      ackLow_d = 1'b0;
    end
    else
    begin
      case (state_q)
        ST_ADDR, ST_RX:
        begin
          if (sclRise)
          begin
            shift_d = {shift_q[6:0], sdaS2_q};
            bitCnt_d = bitCnt_q + 4'h1;
          end
          else if (lastFall)
          begin
            if ((state_q == ST_ADDR) && !addrHit)
              state_d = ST_IDLE;
            else
            begin
              // full buffer: no copy, no ack, flag later
              state_d = ST_ACK;
              setOvf = ovfCond;
              loadBuf = !ovfCond;
              ackLow_d = !ovfCond;
              newDa = (state_q == ST_RX);
              if (state_q == ST_ADDR)
                newRw = shift_q[0];
            end
          end
        end
        ST_ACK:
        begin
          // ninth falling edge ends the acknowledge
          if (sclFall)
          begin
            byteFlag = 1'b1;
            ackLow_d = 1'b0;
            bitCnt_d = 4'h0;
            if (!ackLow_q)
              state_d = ST_IDLE;
            else if (stat_q[`BIT_RW])
            begin
              state_d = ST_TX;
              clrCkp = 1'b1;
            end
            else
              state_d = ST_RX;
          end
        end
        ST_TX:
        begin
          // next bit appears after each falling edge
          if (sclFall)
          begin
            shift_d = {shift_q[6:0], 1'b1};
            bitCnt_d = bitCnt_q + 4'h1;
            if (bitCnt_q == `BYTE_BITS - 4'h1)
              state_d = ST_TXACK;
          end
        end
        ST_TXACK:
        begin
          if (sclRise && sdaS2_q)
          begin
            state_d = ST_IDLE;
            dropStat = 1'b1;
          end
          else if (sclFall)
          begin
            byteFlag = 1'b1;
            clrCkp = 1'b1;
            bitCnt_d = 4'h0;
            state_d = ST_TX;
          end
        end
        default:
          state_d = ST_IDLE;
      endcase
    end
    if (wrBuf)
      shift_d = wData;
    // status: hardware sets win over software clears
    stat_d = stat_q;
    if (wrStat)
      stat_d[7:6] = wData[7:6];
    if (rdBuf)
      stat_d[`BIT_BF] = 1'b0;
    if (loadBuf)
      stat_d[`BIT_BF] = 1'b1;
    stat_d[`BIT_RW] = newRw;
    stat_d[`BIT_DA] = newDa;
    if (dropStat)
    begin
      stat_d[`BIT_DA] = 1'b0;
      stat_d[`BIT_RW] = 1'b0;
      stat_d[`BIT_UA] = 1'b0;
      stat_d[`BIT_BF] = 1'b0;
    end
    if (startEv)
      stat_d[`BIT_STOP:`BIT_START] = 2'h1;
    if (stopEv)
      stat_d[`BIT_STOP:`BIT_START] = 2'h2;
    if (!portOn)
      stat_d[`BIT_STOP:`BIT_START] = 2'h0;
    // control: overflow set and clock hold win
    ctrl_d = wrCtrl ? wData : serCtrl_q;
    if (setOvf)
      ctrl_d[`BIT_OVF] = 1'b1;
    if (clrCkp)
      ctrl_d[`BIT_CKP] = 1'b0;
    // flags: never cleared by hardware
    flags_d = wrFlags ? wData : perFlags_q;
    if (byteFlag || (ssOn && (startEv || stopEv)))
      flags_d[`BIT_IRQ_FLAG] = 1'b1;
    buf_d = wrBuf ? wData : serBuf_q;
    if (loadBuf)
      buf_d = shift_q;
  end

  // engine state
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      state_q <= ST_IDLE;
      shift_q <= `RST_ZERO;
      bitCnt_q <= 4'h0;
      ackLow_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      shift_q <= shift_d;
      bitCnt_q <= bitCnt_d;
      ackLow_q <= ackLow_d;
    end
  end

  // register file
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      intCtrl_q <= `RST_ZERO;
      perFlags_q <= `RST_ZERO;
      perEn_q <= `RST_ZERO;
      serBuf_q <= `RST_ZERO;
      serCtrl_q <= `RST_ZERO;
      portDir_q <= `RST_PORT_DIR;
      slvAddr_q <= `RST_ZERO;
      stat_q <= `RST_ZERO;
    end
    else
    begin
      intCtrl_q <= wrIntCtrl ? wData : intCtrl_q;
      perFlags_q <= flags_d;
      perEn_q <= wrPerEn ? wData : perEn_q;
      serBuf_q <= buf_d;
      serCtrl_q <= ctrl_d;
      portDir_q <= wrDir ? wData : portDir_q;
      slvAddr_q <= wrAddr ? wData : slvAddr_q;
      stat_q <= stat_d;
    end
  end

  // line drivers: direction bit low or slave pull
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      pinOe_q <= 2'h0;
      pinOut_q <= 2'h0;
    end
    else
    begin
      pinOe_q.sda <= ~portDir_q[`BIT_SDA_DIR] | ackLow_q | txBitLow;
      pinOe_q.scl <= ~portDir_q[`BIT_SCL_DIR] |
                     (slvOn && (state_q == ST_TX) && !serCtrl_q[`BIT_CKP]);
      pinOut_q <= 2'h0;
    end
  end

  // apb answer: ready in the first access cycle
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q <= setupPh;
      prdata_q <= setupPh ? {24'h00_0000, rdSel} : prdata_q;
      pslverr_q <= setupPh & ~addrOk;
    end
  end

  assign pready = pready_q;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;
  assign pinOe = pinOe_q;
  assign pinOut = pinOut_q;

  // checks
  default clocking dc @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire quiet = slvOn && !startEv && !stopEv;

  AST_RX_ADDR_LOAD: assert property (
    (quiet && state_q == ST_ADDR && lastFall && addrHit && !ovfCond && !shift_q[0])
    |=> (!stat_q[`BIT_RW] && serBuf_q == $past(shift_q) && stat_q[`BIT_BF]))
    else $error("write address match did not load buffer");
  AST_OVF_NO_ACK: assert property (
    (quiet && state_q == ST_ADDR && lastFall && addrHit && ovfCond)
    |=> (!ackLow_q && serCtrl_q[`BIT_OVF]) ##1 !ackLow_q)
    else $error("acknowledge given during overflow");
  AST_FLAG_STICKY: assert property (
    $fell(perFlags_q[`BIT_IRQ_FLAG]) |-> $past(wrFlags))
    else $error("irq flag cleared without software");
  AST_HOLD_CLOCK: assert property (
    (slvOn && state_q == ST_TX && !serCtrl_q[`BIT_CKP]) |=> pinOe_q.scl)
    else $error("clock not held while release bit low");
  AST_TX_SHIFT: assert property (
    (quiet && state_q == ST_TX && sclFall) |=> shift_q[7:1] == $past(shift_q[6:0]))
    else $error("transmit shift missed a falling edge");
  AST_TX_NINTH_FLAG: assert property (
    (quiet && state_q == ST_TXACK && sclFall) |=> perFlags_q[`BIT_IRQ_FLAG]
    ##0 (state_q == ST_TX) ##0 !serCtrl_q[`BIT_CKP])
    else $error("ninth falling edge did not flag");
  AST_NACK_ENDS: assert property (
    (quiet && state_q == ST_TXACK && sclRise && sdaS2_q)
    |=> (state_q == ST_IDLE && !stat_q[`BIT_RW] && !stat_q[`BIT_BF]))
    else $error("master nack did not end transfer");
  AST_PORT_OFF: assert property (
    !portOn |=> (stat_q[`BIT_STOP:`BIT_START] == 2'h0) [*2])
    else $error("start/stop bits survive disable");
  AST_STOP_FLAG: assert property (
    (ssOn && stopEv) |=> (perFlags_q[`BIT_IRQ_FLAG] && stat_q[`BIT_STOP]))
    else $error("stop did not raise flag");
  AST_DIR_DRIVE: assert property (
    !portDir_q[`BIT_SDA_DIR] |=> (pinOe_q.sda && !pinOut_q.sda))
    else $error("data line not pulled low by direction bit");
  AST_ADDR_MISS: assert property (
    (quiet && state_q == ST_ADDR && lastFall && !addrHit) |=> state_q == ST_IDLE)
    else $error("address mismatch not ignored");
  AST_SAMPLE_RISE: assert property (
    (quiet && state_q == ST_RX && sclRise) |=> shift_q[0] == $past(sdaS2_q))
    else $error("bit not sampled on rising clock");

  COV_READ_MATCH: cover property (state_q == ST_ACK ##[1:1000] state_q == ST_TX);
  COV_RX_BYTE: cover property (state_q == ST_RX ##[1:1000] loadBuf);
  COV_OVERFLOW: cover property (setOvf);
  COV_START_STOP: cover property (startEv ##[1:1000] stopEv);
endmodule
`default_nettype wire

// *** verif/i2c_master_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// behavioural bus master; its clock stands still between frames
module i2c_master_model
(
  // resolved bus lines
  input  wire logic sclLine,
  input  wire logic sdaLine,
  // pull-low enables
  output logic      sclLow,
  output logic      sdaLow
);
  localparam realtime HALF = 62.5; // half of the 125 ns link period
  int stretchErr;                  // stretch waits that ran out

  // lines released at time zero
  initial
  begin
    sclLow = 1'h0;
    sdaLow = 1'h0;
    stretchErr = 0;
  end

  // one clock: data set mid-low, stretch waited out, sampled mid-high
  task automatic pulse(input logic bitOut, output logic bitIn);
    int n;
    n = 0;
    #(HALF/2) sdaLow = !bitOut;
    #(HALF/2) sclLow = 1'h0;
    while (sclLine !== 1'h1 && n < 2000)
    begin
      #10 n++;
    end
    if (n == 2000)
      stretchErr++;
    #(HALF/2) bitIn = sdaLine;
    #(HALF/2) sclLow = 1'h1;
  endtask

  // one byte msb first, then the ninth clock
  task automatic xfer(input logic [7:0] dOut, input logic ackOut,
                      output logic [7:0] dIn, output logic ackIn);
    for (int i = 7; i >= 0; i--)
    begin
      pulse(dOut[i], dIn[i]);
    end
    pulse(ackOut, ackIn);
  endtask

  // start or repeated start: data falls while clock high
  task automatic start();
    #(HALF/2) sdaLow = 1'h0;
    #(HALF/2) sclLow = 1'h0;
    #HALF sdaLow = 1'h1;
    #(HALF/2) sclLow = 1'h1;
  endtask

  // stop: data rises while clock high, then idle
  task automatic stop();
    #(HALF/2) sdaLow = 1'h1;
    #(HALF/2) sclLow = 1'h0;
    #HALF sdaLow = 1'h0;
    #HALF;
  endtask
endmodule
`default_nettype wire

// *** verif/tb_i2c_slave_port.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "i2c_slave_cfg.svh"
module tb_i2c_slave_port;
  import i2c_slave_pkg::*;
  logic        clk;          // system clock
  logic        reset_n;      // synchronous reset
  apb_req_t    apbReq;       // apb request
  logic        pready;       // apb ready
  logic [31:0] prdata;       // apb read data
  logic        pslverr;      // apb error
  bus_pins_t   pinIn;        // resolved line levels
  bus_pins_t   pinOut;       // driven levels
  bus_pins_t   pinOe;        // drive enables
  logic        mSclLow;      // master pulls clock
  logic        mSdaLow;      // master pulls data
  logic [31:0] rd;           // last read data
  logic        rdErr;        // last slave error
  logic [7:0]  din;          // byte seen by master
  logic        ack;          // ninth bit seen by master
  int          err_count;    // mismatches
  int          total_checks; // comparisons
  localparam logic [7:0] REGS [8] = '{`IDX_INT_CTRL, `IDX_PER_FLAGS, `IDX_SER_BUF,
    `IDX_SER_CTRL, `IDX_PORT_DIR, `IDX_PER_EN, `IDX_SLV_ADDR, `IDX_SER_STAT};

  // wired-and lines with pull-ups
  assign pinIn.scl = !(pinOe.scl | mSclLow);
  assign pinIn.sda = !(pinOe.sda | mSdaLow);

  // 100 MHz clock
  always #5 clk = ~clk;

  i2c_slave_port uut (.clk(clk), .reset_n(reset_n), .apbReq(apbReq), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe));
  i2c_master_model mst (.sclLine(pinIn.scl), .sdaLine(pinIn.sda), .sclLow(mSclLow),
    .sdaLow(mSdaLow));

  // counts and verdict
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer, pready awaited under a bound
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    apbReq <= '{psel: 1'h1, penable: 1'h0, pwrite: wr, paddr: {2'h0, idx, 2'h0},
                pwdata: {24'h0, wd}};
    @(posedge clk);
    apbReq.penable <= 1'h1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1)
    begin
      err_count++;
      $display("Error at %0t: no apb answer", $time);
      report_and_stop();
    end
    else
    begin
      // answer taken at the edge where pready is seen high
      rd = prdata;
      rdErr = pslverr;
      apbReq.psel <= 1'h0;
      apbReq.penable <= 1'h0;
    end
  endtask

  // read and compare masked bits
  task automatic rdc(input logic [7:0] idx, input logic [7:0] msk, input logic [7:0] exp);
    apb(1'h0, idx, 8'h00);
    chk(rd & {24'h0, msk}, {24'h0, exp});
  endtask

  // software refills the buffer and then frees the clock
  task automatic rel(input logic [7:0] d);
    apb(1'h1, `IDX_SER_BUF, d);
    apb(1'h1, `IDX_SER_CTRL, 8'h3E);
  endtask

  // main sequence
  initial
  begin
    clk = 1'h0;
    reset_n = 1'h0;
    apbReq = '0;
    err_count = 0;
    total_checks = 0;
    repeat (12) @(posedge clk);
    reset_n <= 1'h1;
    // reset values and an unmapped index
    for (int i = 0; i < 8; i++)
      rdc(REGS[i], 8'hFF, (REGS[i] == `IDX_PORT_DIR) ? 8'hFF : 8'h00);
    apb(1'h0, 8'h20, 8'h00);
    chk({31'h0, rdErr}, 32'h1);
    chk(rd, 32'h0);
    apb(1'h1, `IDX_SLV_ADDR, 8'hA0);
    rdc(`IDX_SLV_ADDR, 8'hFF, 8'hA0);
    rdc(`IDX_SER_STAT, 8'hC0, 8'h00);
    $display("test registers done");
    // receive: address then data byte
    apb(1'h1, `IDX_SER_CTRL, 8'h3E);
    mst.start();
    rdc(`IDX_PER_FLAGS, 8'hFF, 8'h08);
    apb(1'h1, `IDX_PER_FLAGS, 8'h00);
    mst.xfer(8'hA0, 1'h1, din, ack);
    chk({31'h0, ack}, 32'h0);
    rdc(`IDX_SER_STAT, 8'h3F, 8'h09);
    rdc(`IDX_PER_FLAGS, 8'hFF, 8'h08);
    rdc(`IDX_SER_BUF, 8'hFF, 8'hA0);
    mst.xfer(8'h5A, 1'h1, din, ack);
    chk({31'h0, ack}, 32'h0);
    rdc(`IDX_SER_STAT, 8'h3F, 8'h29);
    $display("test receive done");
    // address while the buffer is still full
    mst.start();
    apb(1'h1, `IDX_PER_FLAGS, 8'h00);
    mst.xfer(8'hA0, 1'h1, din, ack);
    chk({31'h0, ack}, 32'h1);
    rdc(`IDX_SER_CTRL, 8'h40, 8'h40);
    rdc(`IDX_PER_FLAGS, 8'hFF, 8'h08);
    rdc(`IDX_SER_BUF, 8'hFF, 8'h5A);
    apb(1'h1, `IDX_SER_CTRL, 8'h3E);
    mst.start();
    mst.xfer(8'hB0, 1'h1, din, ack);
    chk({31'h0, ack}, 32'h1);
    mst.stop();
    rdc(`IDX_SER_STAT, 8'h18, 8'h10);
    $display("test overflow done");
    // transmit with clock stretching
    mst.start();
    mst.xfer(8'hA1, 1'h1, din, ack);
    chk({31'h0, ack}, 32'h0);
    rdc(`IDX_SER_STAT, 8'h3F, 8'h0D);
    rdc(`IDX_SER_CTRL, 8'h10, 8'h00);
    chk({31'h0, pinOe.scl}, 32'h1);
    apb(1'h1, `IDX_PER_FLAGS, 8'h00);
    fork
      mst.xfer(8'hFF, 1'h0, din, ack);
      rel(8'hC3);
    join
    chk({24'h0, din}, 32'hC3);
    // ninth fall reaches the flag only after the line synchronisers
    repeat (4) @(posedge clk);
    rdc(`IDX_PER_FLAGS, 8'hFF, 8'h08);
    fork
      mst.xfer(8'hFF, 1'h1, din, ack);
      rel(8'h3C);
    join
    chk({24'h0, din}, 32'h3C);
    rdc(`IDX_SER_STAT, 8'h27, 8'h00);
    chk({31'h0, pinOe.scl}, 32'h0);
    mst.stop();
    chk(32'(mst.stretchErr), 32'h0);
    $display("test transmit done");
    // firmware master mode, slave idle
    apb(1'h1, `IDX_SER_CTRL, 8'h3B);
    apb(1'h1, `IDX_PER_FLAGS, 8'h00);
    mst.start();
    rdc(`IDX_PER_FLAGS, 8'hFF, 8'h08);
    apb(1'h1, `IDX_PER_FLAGS, 8'h00);
    mst.xfer(8'hA0, 1'h1, din, ack);
    chk({31'h0, ack}, 32'h1);
    mst.stop();
    rdc(`IDX_PER_FLAGS, 8'hFF, 8'h08);
    rdc(`IDX_SER_STAT, 8'h18, 8'h10);
    // direction bits pull the lines
    apb(1'h1, `IDX_PORT_DIR, 8'hE7);
    rdc(`IDX_PORT_DIR, 8'hFF, 8'hE7);
    chk({30'h0, pinOe}, 32'h3);
    chk({30'h0, pinOut}, 32'h0);
    chk({31'h0, pinIn.sda}, 32'h0);
    apb(1'h1, `IDX_PORT_DIR, 8'hFF);
    rdc(`IDX_PORT_DIR, 8'hFF, 8'hFF);
    chk({30'h0, pinOe}, 32'h0);
    chk({31'h0, pinIn.sda}, 32'h1);
    // disabling clears start and stop
    apb(1'h1, `IDX_SER_CTRL, 8'h00);
    rdc(`IDX_SER_STAT, 8'h18, 8'h00);
    $display("test firmware master done");
    report_and_stop();
  end
endmodule
`default_nettype wire
